// File: rtl/cssc_top.sv
// clocked serial slave channel with wishbone registers and select release
// How it works
// - halt trigger bit 1 clears active status and stops; 0 does nothing
// - bits 15/14 pick off, receive only, transmit only or full duplex
// - bit 10 masks error interrupt at 0, allows it at 1
// - parity code 00 none, 01 zero no check, 10 even, 11 odd; the code only stores the field, no parity bit is sent or checked
// - bit 7 shifts msb first at 0, lsb first at 1
// - stop bits 00 none, 01 one, 10 two; 11 refused; the code stores 00 to 10 but sends no stop bit for any of them
// - length 01 nine bits, 10 seven, 11 eight; others refused; the code stores 00 and the engine stays idle with it
// - bit 15 of mode picks prescaler output a or b
// - bit 14 picks divided operation clock or external serial clock
// - bit 8 allows receive pin edge as a start trigger
// - mode 00 clocked serial, 01 async, 10 two wire; 11 refused; the engine runs in 00 only, 01 and 10 are stored and leave it idle
// - mode bit 0 picks transfer end or buffer empty interrupt
// - pending flag reads 1 when requested; mask 1 blocks servicing
// - on select release drive handshake busy, then release it
// - on select release release the transmit data pin
// - select release sets the mask and clears the pending flag
// - go trigger drives handshake ready, then enables its buffer
// - go trigger bit 1 sets active status and waits for transfer
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module cssc_top
  import cssc_pkg::*;
#(
  parameter int MAX_BITS = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic prescaler_output_a_i,
  input wire logic prescaler_output_b_i,
  input wire logic sck_i,
  input wire logic select_n_i,
  input wire logic rxd_i,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  input wire logic handshake_pin_i,
  output logic handshake_pin_o,
  output logic handshake_pin_oe_n_o,
  output logic channel_irq_o,
  output logic channel_error_irq_o
);
  initial begin
    if (MAX_BITS != 9) $error("cssc_top serves nine bit words only");
  end

  logic ack_r;
  logic [15:0] comm_r, mode_r;
  logic [7:0] p1dir_r, p2lvl_r, p2dir_r, irqf_r, irqm_r;
  logic active_r, err_r, rxf_r, txf_r;
  logic [8:0] txbuf_r, rxbuf_r, sh_r;
  logic [3:0] cnt_r;
  logic sout_r;
  logic [2:0] sck_s, cs_s, rx_s, a_s, b_s;
  cssc_seq_e seq_r;

  // byte lane merge for the 16 bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // word length in bits from the length code, zero for refused codes
  function automatic logic [3:0] word_len(input logic [1:0] c);
    case (c)
      DLS_9: word_len = 4'h9;
      DLS_7: word_len = 4'h7;
      DLS_8: word_len = 4'h8;
      default: word_len = 4'h0;
    endcase
  endfunction

  // wishbone decode
  logic acc, wr, ack_edge;
  assign acc = wb_cyc_i & wb_stb_i;
  assign ack_edge = acc & ~ack_r;
  assign wr = acc & wb_we_i & ack_r;
  assign wb_ack_o = ack_r;
  logic wr_comm, wr_mode, wr_go, wr_halt, wr_data, wr_if, wr_mk, wr_p1, wr_p2l, wr_p2d;
  assign wr_comm = wr & (wb_adr_i == ADR_COMM_CFG);
  assign wr_mode = wr & (wb_adr_i == ADR_MODE_CFG);
  assign wr_go = wr & (wb_adr_i == ADR_GO_TRIG) & wb_sel_i[0] & wb_dat_i[CH_BIT];
  assign wr_halt = wr & (wb_adr_i == ADR_HALT_TRIG) & wb_sel_i[0] & wb_dat_i[CH_BIT];
  assign wr_data = wr & (wb_adr_i == ADR_DATA);
  assign wr_if = wr & (wb_adr_i == ADR_IRQ_FLAGS) & wb_sel_i[0];
  assign wr_mk = wr & (wb_adr_i == ADR_IRQ_MASK) & wb_sel_i[0];
  assign wr_p1 = wr & (wb_adr_i == ADR_P1_DIR) & wb_sel_i[0];
  assign wr_p2l = wr & (wb_adr_i == ADR_P2_LVL) & wb_sel_i[0];
  assign wr_p2d = wr & (wb_adr_i == ADR_P2_DIR) & wb_sel_i[0];

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else ack_r <= ack_edge;
  end

  // read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ack_edge) begin
      case (wb_adr_i)
        ADR_COMM_CFG: wb_dat_o <= {16'h0000, comm_r};
        ADR_MODE_CFG: wb_dat_o <= {16'h0000, mode_r};
        ADR_STATUS: wb_dat_o <= {28'h000_0000, txf_r, rxf_r, err_r, active_r};
        ADR_DATA: wb_dat_o <= {23'h00_0000, rxbuf_r};
        ADR_IRQ_FLAGS: wb_dat_o <= {24'h00_0000, irqf_r};
        ADR_IRQ_MASK: wb_dat_o <= {24'h00_0000, irqm_r};
        ADR_P1_DIR: wb_dat_o <= {24'h00_0000, p1dir_r};
        ADR_P2_LVL: wb_dat_o <= {24'h00_0000, p2lvl_r};
        ADR_P2_DIR: wb_dat_o <= {24'h00_0000, p2dir_r};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // two flop synchronisers plus one edge history flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_s <= 3'b000;
      cs_s <= 3'b111;
      rx_s <= 3'b111;
      a_s <= 3'b000;
      b_s <= 3'b000;
    end else begin
      sck_s <= {sck_s[1:0], sck_i};
      cs_s <= {cs_s[1:0], select_n_i};
      rx_s <= {rx_s[1:0], rxd_i};
      a_s <= {a_s[1:0], prescaler_output_a_i};
      b_s <= {b_s[1:0], prescaler_output_b_i};
    end
  end

  // field views
  logic txe, rxe, lsb_first, ext_clk, csi_mode, irq_on_empty;
  logic [3:0] len;
  assign txe = comm_r[TXE_BIT];
  assign rxe = comm_r[RXE_BIT];
  assign lsb_first = comm_r[DIR_BIT];
  assign len = word_len(comm_r[DLS_HI:DLS_LO]);
  assign ext_clk = mode_r[CCS_BIT];
  assign csi_mode = (mode_r[MD_HI:MD_LO] == MD_CSI);
  assign irq_on_empty = mode_r[MD_IRQ];
  // register values a write would leave, checked before they land
  logic [15:0] comm_new, mode_new;
  assign comm_new = merge16(comm_r, wb_dat_i, wb_sel_i);
  assign mode_new = merge16(mode_r, wb_dat_i, wb_sel_i);

  // operation clock tick from the chosen prescaler output
  logic op_tick;
  assign op_tick = mode_r[CKS_BIT] ? (b_s[1] & ~b_s[2]) : (a_s[1] & ~a_s[2]);
  // sample and shift edges from the external clock or the operation clock
  logic smp, shf, sel_on, sel_rel, rx_fall;
  assign smp = ext_clk ? (sck_s[1] & ~sck_s[2]) : op_tick;
  assign shf = ext_clk ? (~sck_s[1] & sck_s[2]) : op_tick;
  assign sel_on = ~cs_s[1];
  assign sel_rel = cs_s[1] & ~cs_s[2];
  assign rx_fall = ~rx_s[1] & rx_s[2];

  // engine runs only for a legal clocked serial setup with a mode chosen
  logic run;
  assign run = active_r & csi_mode & (len != 4'h0) & (txe | rxe) & sel_on;

  // word start and end markers
  logic first_edge, word_done;
  assign first_edge = run & smp & (cnt_r == 4'h0);
  assign word_done = run & smp & (cnt_r == len - 4'h1);
  // loaded flag stops a second load of the same word
  logic sh_r_loaded_r;
  logic load_tx;
  assign load_tx = run & (cnt_r == 4'h0) & txe & txf_r & ~sh_r_loaded_r;

  // incoming bit placed by bit order
  logic [8:0] sh_in;
  always_comb begin
    sh_in = sh_r;
    if (lsb_first) begin
      sh_in = {1'b0, sh_r[8:1]};
      sh_in[len - 4'h1] = rxe ? rx_s[1] : 1'b0;
    end else begin
      sh_in = {sh_r[7:0], rxe ? rx_s[1] : 1'b0};
    end
  end

  // shift register, bit counter and buffers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= 9'h000;
      cnt_r <= 4'h0;
      sh_r_loaded_r <= 1'b0;
      rxbuf_r <= 9'h000;
      txbuf_r <= 9'h000;
    end else begin
      if (!run) begin
        cnt_r <= 4'h0;
        sh_r_loaded_r <= 1'b0;
      end else if (load_tx) begin
        sh_r <= txbuf_r;
        sh_r_loaded_r <= 1'b1;
      end else if (smp) begin
        sh_r <= sh_in;
        if (word_done) begin
          cnt_r <= 4'h0;
          sh_r_loaded_r <= 1'b0;
          if (rxe) rxbuf_r <= sh_in;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
      if (wr_data) txbuf_r <= wb_dat_i[8:0];
    end
  end

  // outgoing bit, updated on the shift edge
  logic out_bit;
  assign out_bit = lsb_first ? sh_r[0] : sh_r[len - 4'h1];
  always_ff @(posedge clk_i) begin
    if (rst_i) sout_r <= 1'b1;
    else if (!run || !txe) sout_r <= 1'b1;
    else if (shf || load_tx) sout_r <= load_tx ? (lsb_first ? txbuf_r[0] :
                                                  txbuf_r[len - 4'h1]) : out_bit;
  end

  // buffer full flags and overrun error, set wins over clear
  logic rd_data;
  assign rd_data = ack_edge & ~wb_we_i & (wb_adr_i == ADR_DATA);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txf_r <= 1'b0;
      rxf_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wr_data) txf_r <= 1'b1;
      else if (load_tx) txf_r <= 1'b0;
      if (word_done && rxe) rxf_r <= 1'b1;
      else if (rd_data) rxf_r <= 1'b0;
      if (word_done && rxe && rxf_r) err_r <= 1'b1;
      else if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[ST_ERR_BIT]) err_r <= 1'b0;
    end
  end

  // select release and go preparation sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) seq_r <= SQ_IDLE;
    else begin
      case (seq_r)
        SQ_IDLE: begin
          if (sel_rel) seq_r <= SQ_TXOFF;
          else if (wr_go) seq_r <= SQ_PREP;
        end
        SQ_TXOFF: seq_r <= SQ_BUSY;
        SQ_BUSY: seq_r <= SQ_HSOFF;
        SQ_HSOFF: seq_r <= SQ_STOP;
        SQ_STOP: seq_r <= SQ_MODE;
        SQ_MODE: seq_r <= SQ_MASK;
        SQ_MASK: seq_r <= SQ_IDLE;
        SQ_PREP: seq_r <= SQ_IDLE;
        default: seq_r <= SQ_IDLE;
      endcase
    end
  end

  // go and halt triggers drive the active status
  always_ff @(posedge clk_i) begin
    if (rst_i) active_r <= 1'b0;
    else if (wr_halt || seq_r == SQ_STOP) active_r <= 1'b0;
    else if (wr_go) active_r <= 1'b1;
    else if (mode_r[STS_BIT] && rx_fall) active_r <= 1'b1;
  end

  // configuration registers, release reprograms them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comm_r <= COMM_RST;
      mode_r <= MODE_RST;
    end else if (seq_r == SQ_MODE) begin
      comm_r <= COMM_REL;
      mode_r <= MODE_REL;
    end else begin
      // a refused stop code leaves the comm register as it was
      if (wr_comm && comm_new[SLC_HI:SLC_LO] != SLC_BAD) begin
        comm_r <= comm_new;
      end
      // a refused function code leaves the mode register as it was
      if (wr_mode && mode_new[MD_HI:MD_LO] != MD_BAD) begin
        mode_r <= mode_new;
      end
    end
  end

  // pin direction and level registers with sequencer overrides
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1dir_r <= DIR_RST;
      p2lvl_r <= LVL_RST;
      p2dir_r <= DIR_RST;
    end else begin
      if (wr_p1) p1dir_r <= wb_dat_i[7:0];
      if (wr_p2l) p2lvl_r <= wb_dat_i[7:0];
      if (wr_p2d) p2dir_r <= wb_dat_i[7:0];
      if (seq_r == SQ_TXOFF) p1dir_r[TXD_PIN_BIT] <= 1'b1;
      if (seq_r == SQ_BUSY) p2lvl_r[HS_PIN_BIT] <= 1'b1;
      if (seq_r == SQ_HSOFF) p2dir_r[HS_PIN_BIT] <= 1'b1;
      if (seq_r == SQ_IDLE && wr_go && !sel_rel) p2lvl_r[HS_PIN_BIT] <= 1'b0;
      if (seq_r == SQ_PREP) p2dir_r[HS_PIN_BIT] <= 1'b0;
    end
  end

  // interrupt pending and mask, event set wins over software clear
  logic irq_evt;
  assign irq_evt = irq_on_empty ? load_tx : word_done;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irqf_r <= 8'h00;
      irqm_r <= MASK_RST;
    end else begin
      if (wr_if) irqf_r <= wb_dat_i[7:0];
      if (wr_mk) irqm_r <= wb_dat_i[7:0];
      if (seq_r == SQ_MASK) begin
        irqm_r[CH_BIT] <= 1'b1;
        irqf_r[CH_BIT] <= 1'b0;
      end
      if (irq_evt) irqf_r[CH_BIT] <= 1'b1;
    end
  end

  // pins and interrupt lines
  assign serial_out_pin_o = sout_r;
  assign serial_out_pin_oe_n_o = p1dir_r[TXD_PIN_BIT];
  assign handshake_pin_o = p2lvl_r[HS_PIN_BIT];
  assign handshake_pin_oe_n_o = p2dir_r[HS_PIN_BIT];
  assign channel_irq_o = irqf_r[CH_BIT] & ~irqm_r[CH_BIT];
  assign channel_error_irq_o = err_r & comm_r[EOC_BIT];

  // checks on the sequencing and register effects
  a_halt_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_halt |=> !active_r) else $error("halt did not clear active");
  a_go_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && !wr_halt && seq_r == SQ_IDLE && !sel_rel |=> active_r)
    else $error("go did not set active");
  a_release_txd: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_r == SQ_IDLE && sel_rel |=> ##1 serial_out_pin_oe_n_o)
    else $error("data pin not released");
  a_busy_before_off: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_r == SQ_BUSY |=> handshake_pin_o ##1 handshake_pin_oe_n_o && handshake_pin_o)
    else $error("handshake not busy then released");
  a_release_order: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_r == SQ_TXOFF |=> seq_r == SQ_BUSY ##1 seq_r == SQ_HSOFF ##1 seq_r == SQ_STOP
    ##1 seq_r == SQ_MODE ##1 seq_r == SQ_MASK) else $error("release order wrong");
  a_mask_set: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_r == SQ_MASK && !irq_evt |=> irqm_r[CH_BIT] && !irqf_r[CH_BIT])
    else $error("release did not mask");
  a_prep_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_r == SQ_PREP |-> !handshake_pin_o ##1 !handshake_pin_oe_n_o)
    else $error("ready not before enable");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_evt |=> irqf_r[CH_BIT]) else $error("irq event did not set pending");
  a_err_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !comm_r[EOC_BIT] |-> !channel_error_irq_o) else $error("error irq not masked");
  a_word_count: assert property (@(posedge clk_i) disable iff (rst_i)
    run |-> cnt_r < len) else $error("bit count past word length");
  c_release: cover property (@(posedge clk_i) disable iff (rst_i) seq_r == SQ_MASK);
  c_word: cover property (@(posedge clk_i) disable iff (rst_i) word_done && rxe);
  c_prep: cover property (@(posedge clk_i) disable iff (rst_i) seq_r == SQ_PREP);
  c_rx_start: cover property (@(posedge clk_i) disable iff (rst_i) mode_r[STS_BIT] && rx_fall);
endmodule

// File: rtl/cssc_pkg.sv
// shared constants for the clocked serial slave channel
package cssc_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] ADR_COMM_CFG = 8'h00;
  localparam logic [7:0] ADR_MODE_CFG = 8'h04;
  localparam logic [7:0] ADR_GO_TRIG = 8'h08;
  localparam logic [7:0] ADR_HALT_TRIG = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_DATA = 8'h14;
  localparam logic [7:0] ADR_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADR_P1_DIR = 8'h20;
  localparam logic [7:0] ADR_P2_LVL = 8'h24;
  localparam logic [7:0] ADR_P2_DIR = 8'h28;
  // comm config field positions
  localparam int TXE_BIT = 15;
  localparam int RXE_BIT = 14;
  localparam int EOC_BIT = 10;
  localparam int PTC_HI = 9;
  localparam int PTC_LO = 8;
  localparam int DIR_BIT = 7;
  localparam int SLC_HI = 5;
  localparam int SLC_LO = 4;
  localparam int DLS_HI = 1;
  localparam int DLS_LO = 0;
  // mode config field positions
  localparam int CKS_BIT = 15;
  localparam int CCS_BIT = 14;
  localparam int STS_BIT = 8;
  localparam int MD_HI = 2;
  localparam int MD_LO = 1;
  localparam int MD_IRQ = 0;
  // pin bit positions, channel bit, flag bits
  localparam int TXD_PIN_BIT = 2;
  localparam int HS_PIN_BIT = 3;
  localparam int CH_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_RXF_BIT = 2;
  localparam int ST_TXF_BIT = 3;
  // reset values and the values written by select release
  localparam logic [15:0] COMM_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] COMM_REL = 16'hC007;
  localparam logic [15:0] MODE_REL = 16'h4021;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LVL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  // field encodings
  localparam logic [1:0] MD_CSI = 2'b00;
  localparam logic [1:0] DLS_9 = 2'b01;
  localparam logic [1:0] DLS_7 = 2'b10;
  localparam logic [1:0] DLS_8 = 2'b11;
  localparam logic [1:0] SLC_BAD = 2'b11;
  localparam logic [1:0] MD_BAD = 2'b11;
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_TXOFF, SQ_BUSY, SQ_HSOFF, SQ_STOP, SQ_MODE, SQ_MASK, SQ_PREP
  } cssc_seq_e;
endpackage

// File: dv/cssc_master_model.sv
// external serial master that selects the channel and clocks words through it
`timescale 1ns/1ps
module cssc_master_model (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic hs_i,
  input wire logic hs_oe_n_i,
  output logic sck_o,
  output logic select_n_o,
  output logic rxd_o
);
  // clock stands low between frames, select idles high
  initial begin
    sck_o = 1'b0;
    select_n_o = 1'b1;
    rxd_o = 1'b1;
  end
  // select, wait for ready, then shift n bits each way
  task automatic frame(input int n, input logic lsb, input logic [8:0] d,
                       output logic [8:0] q, output logic ok);
    int k;
    int b;
    q = '0;
    ok = 1'b0;
    @(posedge clk_i);
    select_n_o <= 1'b0;
    for (k = 0; k < 200 && !ok; k++) begin
      @(posedge clk_i);
      ok = (hs_i === 1'b0) && (hs_oe_n_i === 1'b0);
    end
    repeat (12) @(posedge clk_i);
    for (k = 0; k < n; k++) begin
      b = lsb ? k : n - 1 - k;
      rxd_o <= d[b];
      repeat (7) @(posedge clk_i);
      @(negedge clk_i);
      q[b] = txd_i;
      @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    // line no longer meaningful: show the inverse
    rxd_o <= ~rxd_o;
  endtask
  // one high to low step on the receive line, then back to idle
  task automatic rx_edge();
    @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // release select
  task automatic drop();
    @(posedge clk_i);
    select_n_o <= 1'b1;
  endtask
endmodule

// File: dv/tb.sv
// register-level bench for the clocked serial slave channel
`timescale 1ns/1ps
module tb;
  import cssc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pa = 1'b0, pb = 1'b0;
  logic sck, sel_n, rxd, spin, hpin;
  logic so, so_oe_n, hs, hs_oe_n, irq, eirq;
  logic [3:0] pcnt = 4'h0;
  logic [8:0] q;
  logic ok;
  int failures = 0;
  int checks_done = 0;
  int t0, t1, t2, k;
  always #2.5 clk_i = ~clk_i;
  // prescaler outputs at two different rates
  always @(posedge clk_i) begin
    pcnt <= pcnt + 4'h1;
    pa <= pcnt[1];
    pb <= pcnt[2];
  end
  // undriven pins read back as the inverse
  assign spin = so_oe_n ? ~so : so;
  assign hpin = hs_oe_n ? ~hs : hs;
  cssc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prescaler_output_a_i(pa),
    .prescaler_output_b_i(pb), .sck_i(sck), .select_n_i(sel_n), .rxd_i(rxd),
    .serial_out_pin_i(spin), .serial_out_pin_o(so), .serial_out_pin_oe_n_o(so_oe_n),
    .handshake_pin_i(hpin), .handshake_pin_o(hs), .handshake_pin_oe_n_o(hs_oe_n),
    .channel_irq_o(irq), .channel_error_irq_o(eirq));
  cssc_master_model mst (.clk_i(clk_i), .txd_i(spin), .hs_i(hpin), .hs_oe_n_i(hs_oe_n),
    .sck_o(sck), .select_n_o(sel_n), .rxd_o(rxd));
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    chk({31'd0, s}, {31'd0, e});
  endtask
  // one classic wishbone cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      final_report();
    end
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
    // let the write land before anything looks at its effect
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(r & m, e);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped address
    rd(ADR_COMM_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ADR_MODE_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ADR_IRQ_MASK, 32'h0000_00FF, 32'hFFFF_FFFF);
    rd(ADR_P1_DIR, 32'h0000_00FF, 32'hFFFF_FFFF);
    rd(ADR_P2_LVL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ADR_P2_DIR, 32'h0000_00FF, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    // field storage and refused codes
    wr(ADR_COMM_CFG, 32'h0000_8390);
    rd(ADR_COMM_CFG, 32'h0000_8390, 32'hFFFF_FFFF);
    wr(ADR_COMM_CFG, 32'h0000_C433);
    rd(ADR_COMM_CFG, 32'h0000_8390, 32'hFFFF_FFFF);
    wr(ADR_MODE_CFG, 32'h0000_C101);
    rd(ADR_MODE_CFG, 32'h0000_C101, 32'hFFFF_FFFF);
    wr(ADR_MODE_CFG, 32'h0000_4006);
    rd(ADR_MODE_CFG, 32'h0000_C101, 32'hFFFF_FFFF);
    // full duplex 8 bit msb first from the external clock
    wr(ADR_COMM_CFG, 32'h0000_C403);
    wr(ADR_MODE_CFG, 32'h0000_4000);
    wr(ADR_P1_DIR, 32'h0000_00FB);
    wr(ADR_IRQ_MASK, 32'h0000_00FE);
    wr(ADR_GO_TRIG, 32'h0000_0001);
    @(posedge clk_i);
    chk1(hs, 1'b0);
    chk1(hs_oe_n, 1'b0);
    rd(ADR_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(ADR_DATA, 32'h0000_00A5);
    mst.frame(8, 1'b0, 9'h03C, q, ok);
    chk1(ok, 1'b1);
    if (!ok) final_report();
    chk({23'd0, q}, 32'h0000_00A5);
    rd(ADR_IRQ_FLAGS, 32'h0000_0001, 32'h0000_0001);
    chk1(irq, 1'b1);
    wr(ADR_IRQ_MASK, 32'h0000_00FF);
    chk1(irq, 1'b0);
    wr(ADR_IRQ_MASK, 32'h0000_00FE);
    // 7 bit lsb first without reading: overrun
    wr(ADR_COMM_CFG, 32'h0000_C482);
    wr(ADR_DATA, 32'h0000_005A);
    mst.frame(7, 1'b1, 9'h015, q, ok);
    chk({23'd0, q}, 32'h0000_005A);
    rd(ADR_STATUS, 32'h0000_0007, 32'h0000_0007);
    chk1(eirq, 1'b1);
    rd(ADR_DATA, 32'h0000_0015, 32'h0000_01FF);
    wr(ADR_COMM_CFG, 32'h0000_C082);
    chk1(eirq, 1'b0);
    // select release: order of pin changes, then final state
    t0 = -1;
    t1 = -1;
    t2 = -1;
    mst.drop();
    for (k = 0; k < 30; k++) begin
      @(negedge clk_i);
      if (so_oe_n === 1'b1 && t0 < 0) t0 = k;
      if (hs === 1'b1 && t1 < 0) t1 = k;
      if (hs_oe_n === 1'b1 && t2 < 0) t2 = k;
    end
    chk1(t0 >= 0 && t0 < t1, 1'b1);
    chk1(t1 >= 0 && t1 < t2, 1'b1);
    rd(ADR_STATUS, 32'h0000_0000, 32'h0000_0001);
    rd(ADR_COMM_CFG, 32'h0000_C007, 32'hFFFF_FFFF);
    rd(ADR_MODE_CFG, 32'h0000_4021, 32'hFFFF_FFFF);
    rd(ADR_IRQ_MASK, 32'h0000_0001, 32'h0000_0001);
    rd(ADR_IRQ_FLAGS, 32'h0000_0000, 32'h0000_0001);
    // halt trigger: 0 does nothing, 1 stops
    wr(ADR_GO_TRIG, 32'h0000_0001);
    wr(ADR_HALT_TRIG, 32'h0000_0000);
    rd(ADR_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(ADR_HALT_TRIG, 32'h0000_0001);
    rd(ADR_STATUS, 32'h0000_0000, 32'h0000_0001);
    // receive line edge starts the channel only when enabled
    mst.rx_edge();
    rd(ADR_STATUS, 32'h0000_0000, 32'h0000_0001);
    wr(ADR_MODE_CFG, 32'h0000_4121);
    mst.rx_edge();
    rd(ADR_STATUS, 32'h0000_0001, 32'h0000_0001);
    final_report();
  end
endmodule
